/* File: src/iq_prb_codec.sv */
// Resource-block IQ compressor and decompressor, three-stage pipeline
`timescale 1ns/1ps
module iq_prb_codec
#(
  parameter int NATIVE_W = 24
)
(
  input wire logic ref_clk,
  input wire logic reset,
  input wire logic in_valid,
  input wire iq_codec_pkg::method_t in_method,
  input wire logic in_decompress,
  input wire logic [4:0] in_word_length,
  input wire logic [iq_codec_pkg::PARAM_W-1:0] in_block_param,
  input wire logic [iq_codec_pkg::PRB_SAMPLES*NATIVE_W-1:0] in_samples,
  output logic out_valid,
  output logic [iq_codec_pkg::PARAM_W-1:0] out_block_param,
  output logic [iq_codec_pkg::PRB_SAMPLES*NATIVE_W-1:0] out_samples
);
  import iq_codec_pkg::*;

  if (NATIVE_W < MIN_NATIVE_W || NATIVE_W > MAX_NATIVE_W)
  begin : g_bad_native_w
    $error("NATIVE_W must lie between 16 and 32");
  end

  function automatic logic [5:0] bit_length(input logic [31:0] v);
    logic [5:0] n;
    n = 6'h00;
    for (int i = 0; i < LANE_W; i++)
    begin
      if (v[i])
      begin
        n = 6'(i + 1);
      end
    end
    return n;
  endfunction

  // Input decode
  logic [4:0] fixed_w;
  logic [4:0] eff_w;
  logic [5:0] ext_amt;

  // Stage 0
  logic s0_valid;
  method_t s0_method;
  logic s0_decomp;
  logic [4:0] s0_w;
  logic [PARAM_W-1:0] s0_param;

  // Block statistics
  logic [31:0] mag_m1 [PRB_SAMPLES];
  logic [31:0] mag_abs [PRB_SAMPLES];
  logic [31:0] run_max [PRB_SAMPLES];
  logic [31:0] run_or_m1 [PRB_SAMPLES];
  logic [31:0] run_or_abs [PRB_SAMPLES];
  logic [5:0] bfp_len;
  logic [5:0] next_exponent;
  logic [31:0] bs_ceil;
  logic [7:0] bs_scale_raw;
  logic [7:0] next_scale;
  logic [7:0] next_inverse;
  logic [5:0] mu_len;
  logic [2:0] next_shift;
  logic [PARAM_W-1:0] next_param;

  // Stage 1
  logic s1_valid;
  method_t s1_method;
  logic s1_decomp;
  logic [4:0] s1_w;
  logic [5:0] s1_exponent;
  logic [7:0] s1_scale;
  logic [7:0] s1_inverse;
  logic [2:0] s1_shift;
  logic [PARAM_W-1:0] s1_param;

  // Out-of-range widths fall back to 16; mu-law needs at least 3 bits
  assign fixed_w = (in_word_length == 5'h00 || in_word_length > MAX_WORD_LENGTH) ?
                   MAX_WORD_LENGTH : in_word_length;
  assign eff_w = (in_method == METHOD_MULAW && fixed_w < MULAW_MIN_WORD_LENGTH) ?
                 MULAW_MIN_WORD_LENGTH : fixed_w;
  assign ext_amt = LANE_W6 - {1'b0, eff_w};

  genvar j;
  for (j = 0; j < PRB_SAMPLES; j++)
  begin : g_lane
    logic signed [31:0] raw_native;
    logic signed [31:0] raw_16;
    logic signed [31:0] raw_w;
    logic signed [31:0] next_lane;
    logic signed [31:0] s0_lane;
    logic signed [31:0] s1_lane;
    logic signed [31:0] lane_res;
    logic [NATIVE_W-1:0] out_lane;

    assign raw_native = 32'($signed(in_samples[j*NATIVE_W +: NATIVE_W]));
    assign raw_16 = 32'($signed(in_samples[j*NATIVE_W +: SAMPLE16_W]));
    assign raw_w = (raw_native <<< ext_amt) >>> ext_amt;
    // Block scaling and mu-law see only the low 16 bits of a native lane
    assign next_lane = in_decompress ? raw_w :
                       (in_method == METHOD_BFP) ? raw_native : raw_16;

    assign mag_m1[j] = s0_lane[31] ? ~s0_lane : s0_lane;
    assign mag_abs[j] = s0_lane[31] ? -s0_lane : s0_lane;

    if (j == 0)
    begin : g_first
      assign run_max[j] = mag_m1[j];
      assign run_or_m1[j] = mag_m1[j];
      assign run_or_abs[j] = mag_abs[j];
    end
    else
    begin : g_chain
      assign run_max[j] = (mag_m1[j] > run_max[j-1]) ? mag_m1[j] : run_max[j-1];
      assign run_or_m1[j] = run_or_m1[j-1] | mag_m1[j];
      assign run_or_abs[j] = run_or_abs[j-1] | mag_abs[j];
    end

    always_ff @(posedge ref_clk)
    begin
      if (reset)
      begin
        s0_lane <= 32'sh00000000;
        s1_lane <= 32'sh00000000;
        out_lane <= '0;
      end
      else
      begin
        s0_lane <= next_lane;
        s1_lane <= s0_lane;
        out_lane <= lane_res[NATIVE_W-1:0];
      end
    end

    iq_lane_xform u_xform
    (
      .method(s1_method),
      .decompress(s1_decomp),
      .word_length(s1_w),
      .exponent(s1_exponent),
      .block_scale_factor(s1_scale),
      .inverse_scale_factor(s1_inverse),
      .block_left_shift(s1_shift),
      .sample_in(s1_lane),
      .sample_out(lane_res)
    );

    // Element k occupies lanes 2k (I) and 2k+1 (Q), order kept end to end
    assign out_samples[j*NATIVE_W +: NATIVE_W] = out_lane;
  end

  // OR of magnitudes has the same bit length as their maximum
  assign bfp_len = bit_length(run_or_m1[PRB_SAMPLES-1]);
  assign next_exponent = (bfp_len + 6'd1 > {1'b0, s0_w}) ?
                         bfp_len + 6'd1 - {1'b0, s0_w} : 6'h00;

  assign bs_ceil = (run_max[PRB_SAMPLES-1] + BS_CEIL_ADD) >> BS_SCALE_SHIFT;
  assign bs_scale_raw = bs_ceil[7:0];
  assign next_scale = (bs_scale_raw == 8'h00) ? 8'h01 : bs_scale_raw;
  // A divider here is cheaper than a 128-entry table at this clock rate
  assign next_inverse = BS_UNITY / next_scale;

  assign mu_len = bit_length(run_or_abs[PRB_SAMPLES-1]);
  assign next_shift = (mu_len >= MULAW_SHIFT_BITLEN_REF) ? 3'h0 :
                      (mu_len <= MULAW_SHIFT_MIN_BITLEN) ? MULAW_MAX_SHIFT :
                      3'(MULAW_SHIFT_BITLEN_REF - mu_len);

  assign next_param = s0_decomp ? s0_param :
                      (s0_method == METHOD_BFP) ? {2'b00, next_exponent} :
                      (s0_method == METHOD_BLOCK_SCALE) ? next_scale :
                      {5'b00000, next_shift};

  always_ff @(posedge ref_clk)
  begin
    if (reset)
    begin
      s0_valid <= 1'b0;
      s0_method <= METHOD_BFP;
      s0_decomp <= 1'b0;
      s0_w <= MAX_WORD_LENGTH;
      s0_param <= '0;
    end
    else
    begin
      s0_valid <= in_valid;
      s0_method <= in_method;
      s0_decomp <= in_decompress;
      s0_w <= eff_w;
      s0_param <= in_block_param;
    end
  end

  always_ff @(posedge ref_clk)
  begin
    if (reset)
    begin
      s1_valid <= 1'b0;
      s1_method <= METHOD_BFP;
      s1_decomp <= 1'b0;
      s1_w <= MAX_WORD_LENGTH;
      s1_exponent <= 6'h00;
      s1_scale <= 8'h01;
      s1_inverse <= BS_UNITY;
      s1_shift <= 3'h0;
      s1_param <= '0;
    end
    else
    begin
      s1_valid <= s0_valid;
      s1_method <= s0_method;
      s1_decomp <= s0_decomp;
      s1_w <= s0_w;
      s1_exponent <= s0_decomp ? s0_param[5:0] : next_exponent;
      s1_scale <= s0_decomp ? s0_param : next_scale;
      s1_inverse <= next_inverse;
      s1_shift <= s0_decomp ? s0_param[2:0] : next_shift;
      s1_param <= next_param;
    end
  end

  always_ff @(posedge ref_clk)
  begin
    if (reset)
    begin
      out_valid <= 1'b0;
      out_block_param <= '0;
    end
    else
    begin
      out_valid <= s1_valid;
      out_block_param <= s1_param;
    end
  end
endmodule

/* File: src/iq_codec_pkg.sv */
// Shared constants and types of the resource-block IQ codec
package iq_codec_pkg;
  localparam int PRB_ELEMENTS = 12;
  localparam int PRB_SAMPLES = 24;
  localparam int LANE_W = 32;
  localparam int PARAM_W = 8;
  localparam int SAMPLE16_W = 16;
  localparam int MIN_NATIVE_W = 16;
  localparam int MAX_NATIVE_W = 32;
  localparam int PIPE_LATENCY = 3;
  localparam logic [4:0] MAX_WORD_LENGTH = 5'h10;
  localparam logic [4:0] MULAW_MIN_WORD_LENGTH = 5'h03;
  localparam logic [5:0] LANE_W6 = 6'h20;
  localparam logic [31:0] BS_CEIL_ADD = 32'h000000ff;
  localparam int BS_SCALE_SHIFT = 8;
  localparam logic [7:0] BS_UNITY = 8'h80;
  localparam logic [4:0] BS_COMP_REF = 5'h10;
  localparam logic [4:0] BS_DECOMP_REF = 5'h09;
  localparam int COMPANDING_MAGNITUDE_WIDTH = 15;
  localparam logic [5:0] MULAW_SHIFT_BITLEN_REF = 6'h0f;
  localparam logic [5:0] MULAW_SHIFT_MIN_BITLEN = 6'h08;
  localparam logic [2:0] MULAW_MAX_SHIFT = 3'h7;
  localparam logic signed [31:0] MULAW_SAT = 32'sh00007fff;
  localparam logic signed [31:0] MULAW_SEG1_LIMIT = 32'sh00002000;
  localparam logic signed [31:0] MULAW_SEG2_LIMIT = 32'sh00004000;
  localparam logic signed [31:0] MULAW_SEG1_OFFSET = 32'sh00002000;
  localparam logic signed [31:0] MULAW_SEG2_OFFSET = 32'sh00008000;
  localparam logic signed [31:0] SAT16_MAX = 32'sh00007fff;
  localparam logic signed [31:0] SAT16_MIN = 32'shffff8000;

  typedef enum logic [2:0] {
    METHOD_BFP = 3'b001,
    METHOD_BLOCK_SCALE = 3'b010,
    METHOD_MULAW = 3'b100
  } method_t;
endpackage

/* File: src/iq_lane_xform.sv */
// One I or Q sample through the selected compress or decompress method
`timescale 1ns/1ps
module iq_lane_xform
(
  input wire iq_codec_pkg::method_t method,
  input wire logic decompress,
  input wire logic [4:0] word_length,
  input wire logic [5:0] exponent,
  input wire logic [7:0] block_scale_factor,
  input wire logic [7:0] inverse_scale_factor,
  input wire logic [2:0] block_left_shift,
  input wire logic signed [31:0] sample_in,
  output logic signed [31:0] sample_out
);
  import iq_codec_pkg::*;

  function automatic logic signed [31:0] clip(input logic signed [40:0] v,
                                              input logic signed [31:0] lo,
                                              input logic signed [31:0] hi);
    logic signed [31:0] r;
    r = v[31:0];
    if (v > hi)
    begin
      r = hi;
    end
    else if (v < lo)
    begin
      r = lo;
    end
    return r;
  endfunction

  logic signed [31:0] q_max;
  logic signed [31:0] q_min;
  logic signed [31:0] bfp_value;
  logic [4:0] bs_sh;
  logic signed [40:0] bs_prod;
  logic signed [40:0] bs_half;
  logic signed [31:0] bs_comp;
  logic [4:0] bs_dsh;
  logic signed [40:0] bs_dprod;
  logic signed [40:0] bs_dhalf;
  logic signed [40:0] bs_dscaled;
  logic signed [31:0] bs_decomp;
  logic [4:0] dbl_ref;
  logic mu_neg;
  logic signed [31:0] mu_abs;
  logic signed [31:0] mu_shl;
  logic signed [31:0] mu_sat;
  logic [4:0] mu_seg_sh;
  logic signed [31:0] mu_seg_add;
  logic signed [31:0] mu_half;
  logic signed [31:0] mu_mag;
  logic signed [31:0] mu_mag_c;
  logic signed [31:0] mu_comp;
  logic signed [31:0] md_m;
  logic signed [31:0] md_quarter;
  logic signed [31:0] md_eighth;
  logic signed [31:0] md_dbl;
  logic signed [31:0] md_signed;
  logic signed [31:0] mu_decomp;

  assign q_max = (32'sd1 <<< (word_length - 5'd1)) - 32'sd1;
  assign q_min = -q_max - 32'sd1;

  // Truncating shift keeps the word inside w bits without a saturator
  assign bfp_value = decompress ? (sample_in <<< exponent) : (sample_in >>> exponent);

  assign bs_sh = BS_COMP_REF - word_length;
  assign bs_prod = $signed({1'b0, inverse_scale_factor}) * sample_in;
  assign bs_half = (bs_sh == 5'd0) ? 41'sd0 : (41'sd1 <<< (bs_sh - 5'd1));
  assign bs_comp = clip((bs_prod + bs_half) >>> bs_sh, q_min, q_max);

  // Below 9 bits the divide turns into a multiply
  assign bs_dsh = (word_length >= BS_DECOMP_REF) ? word_length - BS_DECOMP_REF
                                                 : BS_DECOMP_REF - word_length;
  assign bs_dprod = $signed({1'b0, block_scale_factor}) * sample_in;
  assign bs_dhalf = (word_length > BS_DECOMP_REF) ? (41'sd1 <<< (bs_dsh - 5'd1)) : 41'sd0;
  assign bs_dscaled = (word_length >= BS_DECOMP_REF) ? ((bs_dprod + bs_dhalf) >>> bs_dsh)
                                                     : (bs_dprod <<< bs_dsh);
  assign bs_decomp = clip(bs_dscaled, SAT16_MIN, SAT16_MAX);

  // Doubled magnitudes keep every shift non-negative up to 16-bit words
  assign dbl_ref = 5'(COMPANDING_MAGNITUDE_WIDTH + 1);
  assign mu_neg = sample_in[31];
  assign mu_abs = mu_neg ? -sample_in : sample_in;
  assign mu_shl = mu_abs <<< block_left_shift;
  assign mu_sat = (mu_shl > MULAW_SAT) ? MULAW_SAT : mu_shl;
  assign mu_seg_sh = (mu_sat <= MULAW_SEG1_LIMIT) ? dbl_ref - word_length :
                     (mu_sat <= MULAW_SEG2_LIMIT) ? dbl_ref + 5'd1 - word_length :
                     dbl_ref + 5'd2 - word_length;
  assign mu_seg_add = (mu_sat <= MULAW_SEG1_LIMIT) ? 32'sd0 :
                      (mu_sat <= MULAW_SEG2_LIMIT) ? (32'sd1 <<< (word_length - 5'd3)) :
                      (32'sd1 <<< (word_length - 5'd2));
  assign mu_half = (mu_seg_sh == 5'd0) ? 32'sd0 : (32'sd1 <<< (mu_seg_sh - 5'd1));
  assign mu_mag = (((mu_sat <<< 1) + mu_half) >>> mu_seg_sh) + mu_seg_add;
  assign mu_mag_c = (mu_mag > q_max) ? q_max : mu_mag;
  assign mu_comp = mu_neg ? -mu_mag_c : mu_mag_c;

  assign md_m = (mu_abs > q_max) ? q_max : mu_abs;
  assign md_quarter = 32'sd1 <<< (word_length - 5'd2);
  assign md_eighth = 32'sd1 <<< (word_length - 5'd3);
  assign md_dbl = (md_m <= md_quarter) ? (md_m <<< (dbl_ref - word_length)) :
                  (md_m <= md_quarter + md_eighth) ?
                  (md_m <<< (dbl_ref + 5'd1 - word_length)) - (MULAW_SEG1_OFFSET <<< 1) :
                  (md_m <<< (dbl_ref + 5'd2 - word_length)) - (MULAW_SEG2_OFFSET <<< 1);
  assign md_signed = mu_neg ? -(md_dbl >>> 1) : (md_dbl >>> 1);
  assign mu_decomp = md_signed >>> block_left_shift;

  assign sample_out = (method == METHOD_BFP) ? bfp_value :
                      (method == METHOD_BLOCK_SCALE) ? (decompress ? bs_decomp : bs_comp) :
                      (method == METHOD_MULAW) ? (decompress ? mu_decomp : mu_comp) :
                      32'sd0;
endmodule

/* File: sim/iq_prb_codec_asserts.sv */
// Port checks of the resource-block IQ codec
`timescale 1ns/1ps
module iq_prb_codec_asserts
#(
  parameter int NATIVE_W = 24
)
(
  input wire logic ref_clk,
  input wire logic reset,
  input wire logic in_valid,
  input wire iq_codec_pkg::method_t in_method,
  input wire logic in_decompress,
  input wire logic [4:0] in_word_length,
  input wire logic [7:0] in_block_param,
  input wire logic [24*NATIVE_W-1:0] in_samples,
  input wire logic out_valid,
  input wire logic [7:0] out_block_param,
  input wire logic [24*NATIVE_W-1:0] out_samples
);
  import iq_codec_pkg::*;
  default clocking @(posedge ref_clk); endclocking
  default disable iff (reset);
  chk_valid_latency: assert property (in_valid |-> ##3 out_valid)
    else $error("answer late");
  chk_no_stray: assert property (out_valid |-> $past(in_valid, 3))
    else $error("answer without block");
  chk_reset_quiet: assert property ($fell(reset) |-> !out_valid [*3])
    else $error("answer too soon after reset");
  chk_param_echo: assert property (out_valid && $past(in_decompress, 3) |->
    out_block_param == $past(in_block_param, 3)) else $error("param not echoed");
  chk_mulaw_zero: assert property (out_valid && $past(in_samples, 3) == '0 &&
    $past(in_method, 3) == METHOD_MULAW && !$past(in_decompress, 3) |->
    out_block_param == 8'h07 && out_samples == '0) else $error("quiet shift wrong");
  chk_scale_range: assert property (out_valid && !$past(in_decompress, 3) &&
    $past(in_method, 3) == METHOD_BLOCK_SCALE |-> out_block_param inside {[8'h01:8'h80]})
    else $error("scale out of range");
  chk_exp_limit: assert property (out_valid && !$past(in_decompress, 3) &&
    $past(in_method, 3) == METHOD_BFP && $past(in_word_length, 3) == 5'h10 |->
    out_block_param <= NATIVE_W - 16) else $error("exponent too large");
  chk_bfp_unity: assert property (out_valid && $past(in_decompress, 3) &&
    $past(in_method, 3) == METHOD_BFP && $past(in_block_param, 3) == 8'h00 &&
    $past(in_word_length, 3) == 5'h10 |-> $signed(out_samples[NATIVE_W-1:0]) ==
    $signed($past(in_samples[15:0], 3))) else $error("unity restore wrong");
endmodule

/* File: sim/framer_model.sv */
// Far-side framer model collecting finished blocks in arrival order
`timescale 1ns/1ps
module framer_model
#(
  parameter int VW = 576
)
(
  input wire logic ref_clk,
  input wire logic out_valid,
  input wire logic [7:0] out_block_param,
  input wire logic [VW-1:0] out_samples
);
  logic [7:0] got_param [$];
  logic [VW-1:0] got_samples [$];
  // No backpressure, so every valid cycle must be taken
  always @(posedge ref_clk)
  begin
    if (out_valid === 1'b1)
    begin
      got_param.push_back(out_block_param);
      got_samples.push_back(out_samples);
    end
  end
endmodule

/* File: sim/iq_prb_codec_tb.sv */
// Self-checking bench of the resource-block IQ codec
`timescale 1ns/1ps
module iq_prb_codec_tb;
  import iq_codec_pkg::*;
  localparam int NW = 24;
  localparam int VW = PRB_SAMPLES * NW;
  logic ref_clk = 1'b0;
  logic reset = 1'b1;
  logic in_valid = 1'b0;
  method_t in_method = METHOD_BFP;
  logic in_decompress = 1'b0;
  logic [4:0] in_word_length = 5'h10;
  logic [7:0] in_block_param = 8'h00;
  logic [VW-1:0] in_samples = '0;
  logic out_valid;
  logic [7:0] out_block_param;
  logic [VW-1:0] out_samples;
  logic [7:0] exp_param [$];
  logic [VW-1:0] exp_samples [$];
  logic [31:0] seed = 32'he696bcb3;
  int pk [8] = '{16384, 16383, 257, 256, 255, 0, -32768, -257};
  int error_cnt = 0, checked = 0, cycles = 0;
  iq_prb_codec #(.NATIVE_W(NW)) iq_prb_codec_inst (.ref_clk(ref_clk), .reset(reset),
    .in_valid(in_valid), .in_method(in_method), .in_decompress(in_decompress),
    .in_word_length(in_word_length), .in_block_param(in_block_param),
    .in_samples(in_samples), .out_valid(out_valid), .out_block_param(out_block_param),
    .out_samples(out_samples));
  framer_model #(.VW(VW)) framer_model_inst (.ref_clk(ref_clk), .out_valid(out_valid),
    .out_block_param(out_block_param), .out_samples(out_samples));
  initial
  begin
    forever #12.5 ref_clk = ~ref_clk;
  end
  function automatic logic [31:0] rnd();
    seed = {seed[30:0], 1'b0} ^ (seed[31] ? 32'h04c11db7 : 32'h0);
    return seed;
  endfunction
  function automatic int sx(logic [31:0] v, int n);
    return $signed(v << (32 - n)) >>> (32 - n);
  endfunction
  // Random width n gives small and full-scale blocks alike
  function automatic logic [VW-1:0] fill(int n);
    logic [VW-1:0] s;
    for (int k = 0; k < PRB_SAMPLES; k++)
      s[k*NW +: NW] = NW'(sx(rnd(), n));
    return s;
  endfunction
  function automatic void model(method_t m, logic d, logic [4:0] wl, logic [7:0] p,
      logic [VW-1:0] s, output logic [7:0] ep, output logic [VW-1:0] es);
    int w, x, v, a, mx, len, e, g, t, hi, sc;
    w = (wl == 0 || wl > 16) ? 16 : wl;
    w = (m == METHOD_MULAW && w < 3) ? 3 : w;
    hi = (1 << (w - 1)) - 1;
    mx = 0;
    len = 0;
    for (int k = 0; k < PRB_SAMPLES; k++)
    begin
      x = sx(s[k*NW +: NW], m == METHOD_BFP ? NW : 16);
      a = x >= 0 ? x : (m == METHOD_MULAW ? -x : ~x);
      mx = a > mx ? a : mx;
    end
    while ((mx >> len) != 0)
      len++;
    e = len + 1 > w ? len + 1 - w : 0;
    g = len >= 15 ? 0 : (len <= 8 ? 7 : 15 - len);
    sc = (mx + 255) >> 8;
    sc = sc == 0 ? 1 : sc;
    ep = d ? p : 8'(m == METHOD_BFP ? e : (m == METHOD_MULAW ? g : sc));
    for (int k = 0; k < PRB_SAMPLES; k++)
    begin
      x = sx(s[k*NW +: NW], d ? w : (m == METHOD_BFP ? NW : 16));
      a = (x < 0 ? -x : x) << g;
      a = a > 32767 ? 32767 : a;
      len = a <= 8192 ? 0 : (a <= 16384 ? 1 : 2);
      t = 16 - w + len;
      if (m == METHOD_BFP)
        v = d ? x << p[5:0] : x >>> e;
      else if (d && m == METHOD_BLOCK_SCALE)
      begin
        v = x * int'(p);
        v = w >= 9 ? (v + (w > 9 ? 1 << (w - 10) : 0)) >>> (w - 9) : v << (9 - w);
        v = v > 32767 ? 32767 : (v < -32768 ? -32768 : v);
      end
      else if (d)
      begin
        a = x < 0 ? -x : x;
        a = a > hi ? hi : a;
        t = 1 << (w - 2);
        v = a <= t ? a << (16 - w) :
            (a <= t + t / 2 ? (a << (17 - w)) - 16384 : (a << (18 - w)) - 65536);
        v = x < 0 ? -(v >>> 1) : v >>> 1;
        v = v >>> p[2:0];
      end
      else if (m == METHOD_BLOCK_SCALE)
      begin
        v = (128 / sc) * x;
        v = w < 16 ? (v + (1 << (15 - w))) >>> (16 - w) : v;
        v = v > hi ? hi : (v < -hi - 1 ? -hi - 1 : v);
      end
      else
      begin
        v = ((2 * a + ((1 << t) >> 1)) >> t) + (len == 0 ? 0 : 1 << (w - 4 + len));
        v = v > hi ? hi : v;
        v = x < 0 ? -v : v;
      end
      es[k*NW +: NW] = v[NW-1:0];
    end
  endfunction
  task automatic check(logic [VW-1:0] got, logic [VW-1:0] want);
    checked++;
    if (got !== want)
    begin
      error_cnt++;
      $display("ERROR at %0t got %h want %h", $time, got, want);
    end
  endtask
  task automatic summarize();
    if (error_cnt == 0 && checked > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask
  task automatic send(method_t m, logic d, logic [4:0] w, logic [7:0] p, logic [VW-1:0] s);
    logic [7:0] ep;
    logic [VW-1:0] es;
    model(m, d, w, p, s, ep, es);
    exp_param.push_back(ep);
    exp_samples.push_back(es);
    @(posedge ref_clk);
    in_valid <= 1'b1;
    in_method <= m;
    in_decompress <= d;
    in_word_length <= w;
    in_block_param <= p;
    in_samples <= s;
  endtask
  task automatic idle();
    @(posedge ref_clk);
    in_valid <= 1'b0;
  endtask
  // Falling edge, so the framer has already queued the block
  always @(negedge ref_clk)
  begin
    cycles++;
    if (cycles == 3000)
    begin
      error_cnt++;
      summarize();
    end
    if (framer_model_inst.got_param.size() > 0)
    begin
      check(framer_model_inst.got_param.pop_front(), exp_param.pop_front());
      check(framer_model_inst.got_samples.pop_front(), exp_samples.pop_front());
    end
  end
  initial
  begin
    logic [VW-1:0] s;
    logic [31:0] r;
    method_t m;
    repeat (16) @(posedge ref_clk);
    reset <= 1'b0;
    foreach (pk[i])
    begin
      s = '0;
      s[NW-1:0] = pk[i][NW-1:0];
      send(METHOD_MULAW, 1'b0, 5'h09, 8'h00, s);
      send(METHOD_BLOCK_SCALE, 1'b0, 5'h08, 8'h00, s);
    end
    send(METHOD_BFP, 1'b1, 5'h10, 8'h00, fill(16));
    send(METHOD_BFP, 1'b0, 5'h00, 8'h00, fill(32));
    send(METHOD_BLOCK_SCALE, 1'b1, 5'h09, 8'h80, fill(9));
    send(METHOD_MULAW, 1'b1, 5'h09, 8'h03, fill(9));
    // Every method is decompressed as well as compressed
    repeat (300)
    begin
      r = rnd();
      m = method_t'(3'h1 << (r % 3));
      send(m, r[8], 5'(r[20:16] % 17), 8'(rnd()), fill(32 - r[28:24]));
      if (r[31])
        idle();
    end
    repeat (6) idle();
    check(VW'(exp_param.size()), '0);
    summarize();
  end
endmodule
bind iq_prb_codec iq_prb_codec_asserts #(.NATIVE_W(NATIVE_W)) iq_prb_codec_asserts_inst (
  .ref_clk(ref_clk), .reset(reset), .in_valid(in_valid), .in_method(in_method),
  .in_decompress(in_decompress), .in_word_length(in_word_length),
  .in_block_param(in_block_param), .in_samples(in_samples), .out_valid(out_valid),
  .out_block_param(out_block_param), .out_samples(out_samples));
